// File: hdl/rsc_map.svh
// constants for the reset and suspend control block
`ifndef RSC_MAP_SVH
`define RSC_MAP_SVH

// ----------------------------------------------------------------
// pin positions in the synchronised vector
// ----------------------------------------------------------------
`define RSC_PIN_COLD_N   0
`define RSC_PIN_BUS_N    1
`define RSC_PIN_SUSPEND  2
`define RSC_PIN_COUNT    3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RSC_SYNC_RST     3'h0
`define RSC_CFG_RST      8'h00
`define RSC_WAKE_RST     8'h00

`endif

// File: hdl/rsc_pkg.sv
// types shared by the reset and suspend control block
package rsc_pkg;

  typedef enum logic [2:0] {
    RSC_ST_INIT = 3'b000,
    RSC_ST_COLD = 3'b001,
    RSC_ST_BUS  = 3'b010,
    RSC_ST_HOLD = 3'b011,
    RSC_ST_RUN  = 3'b100
  } rsc_state_t;

endpackage

// File: hdl/rsc_pin_if.sv
// synchronised reset and suspend levels passed between block modules
`timescale 1ns/1ps
`default_nettype none

interface rsc_pin_if;
  logic cold_n;
  logic bus_n;
  logic suspend;

  modport src (output cold_n, output bus_n, output suspend);
  modport dst (input cold_n, input bus_n, input suspend);
endinterface

`default_nettype wire

// File: hdl/rsc_sync.sv
// two-stage synchroniser for the reset and suspend pins
`timescale 1ns/1ps
`default_nettype none
`include "rsc_map.svh"

module rsc_sync #(
  parameter int WIDTH = `RSC_PIN_COUNT
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // raw pins
  input  wire logic [WIDTH-1:0] i_pins,
  // synchronised levels
  rsc_pin_if.src                pin
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // ----------------------------------------------------------------
  // per-bit stages
  // ----------------------------------------------------------------
  // reset value 0 reads as both resets asserted: safe, floated
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      always_ff @(posedge i_clk)
      begin
        if (i_rst)
        begin
          meta_q[g] <= 1'b0;
          sync_q[g] <= 1'b0;
        end
        else
        begin
          meta_q[g] <= i_pins[g];
          sync_q[g] <= meta_q[g];
        end
      end
    end
  endgenerate

  assign pin.cold_n  = sync_q[`RSC_PIN_COLD_N];
  assign pin.bus_n   = sync_q[`RSC_PIN_BUS_N];
  assign pin.suspend = sync_q[`RSC_PIN_SUSPEND];

endmodule

`default_nettype wire

// File: hdl/rsc_top.sv
// reset and suspend control: decides clearing, preserving and floating
`timescale 1ns/1ps
`default_nettype none
`include "rsc_map.svh"

// Notes on behaviour
// - while cold reset is asserted without suspend outputs float, every register clears and the block sits at its defaults.
// - with suspend enabled, cold reset floats the outputs but leaves every register as it was.
// - while bus reset is asserted without suspend outputs float and only the bus-class registers clear.
// - nothing works while bus reset is asserted: user writes are ignored.
// - after bus reset without suspend is released the block runs with cfg at its default and the wake context kept.
// - suspend together with bus reset floats the outputs and keeps every register.
// - all bus-side inputs are sampled on the rising edge of the bus clock.
module rsc_top #(
  parameter int DATA_W = 8
) (
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  // reset and suspend pins from the host
  input  wire logic              i_cold_global_reset_n,
  input  wire logic              i_host_bus_reset_n,
  input  wire logic              i_suspend,
  // user-side register writes
  input  wire logic              i_wr_cfg,
  input  wire logic              i_wr_wake,
  input  wire logic [DATA_W-1:0] i_wr_data,
  // user-side status
  output logic                   o_out_en,
  output logic                   o_func_en,
  output logic                   o_clr_all,
  output logic                   o_clr_bus,
  output logic [2:0]             o_state,
  // register contents
  output logic [DATA_W-1:0]      o_cfg,
  output logic [DATA_W-1:0]      o_wake_ctx
);

  rsc_pin_if pin ();

  rsc_pkg::rsc_state_t state_q;
  rsc_pkg::rsc_state_t state_d;

  logic              out_en_q;
  logic              func_en_q;
  logic              clr_all_q;
  logic              clr_bus_q;
  logic              wr_ok;
  logic [DATA_W-1:0] cfg_q;
  logic [DATA_W-1:0] wake_q;

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  // pins come from the host, so two flops before any decision
  rsc_sync #(
    .WIDTH (`RSC_PIN_COUNT)
  ) u_sync (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_pins ({i_suspend, i_host_bus_reset_n, i_cold_global_reset_n}),
    .pin    (pin)
  );

  // ----------------------------------------------------------------
  // reset class decision
  // ----------------------------------------------------------------
  // cold reset outranks bus reset; suspend turns either into a hold
  always_comb
  begin
    if (!pin.cold_n)
    begin
      if (pin.suspend)
      begin
        state_d = rsc_pkg::RSC_ST_HOLD;
      end
      else
      begin
        state_d = rsc_pkg::RSC_ST_COLD;
      end
    end
    else if (!pin.bus_n)
    begin
      if (pin.suspend)
      begin
        state_d = rsc_pkg::RSC_ST_HOLD;
      end
      else
      begin
        state_d = rsc_pkg::RSC_ST_BUS;
      end
    end
    else
    begin
      state_d = rsc_pkg::RSC_ST_RUN;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state_q <= rsc_pkg::RSC_ST_INIT;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // output buffer and function enables
  // ----------------------------------------------------------------
  // every reset class floats the pins, including the suspend hold
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      out_en_q  <= 1'b0;
      func_en_q <= 1'b0;
    end
    else
    begin
      out_en_q  <= (state_d == rsc_pkg::RSC_ST_RUN);
      func_en_q <= (state_d == rsc_pkg::RSC_ST_RUN);
    end
  end

  // ----------------------------------------------------------------
  // clear strobes for the rest of the chip
  // ----------------------------------------------------------------
  // held as levels for the whole reset, so late-starting logic still sees them
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      clr_all_q <= 1'b1;
      clr_bus_q <= 1'b1;
    end
    else
    begin
      case (state_d)
        rsc_pkg::RSC_ST_COLD:
        begin
          clr_all_q <= 1'b1;
          clr_bus_q <= 1'b1;
        end
        rsc_pkg::RSC_ST_BUS:
        begin
          clr_all_q <= 1'b0;
          clr_bus_q <= 1'b1;
        end
        rsc_pkg::RSC_ST_HOLD:
        begin
          clr_all_q <= 1'b0;
          clr_bus_q <= 1'b0;
        end
        default:
        begin
          clr_all_q <= 1'b0;
          clr_bus_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register contents
  // ----------------------------------------------------------------
  // writes land only while running, never in the cycle a reset is seen
  assign wr_ok = (state_q == rsc_pkg::RSC_ST_RUN) &&
                 (state_d == rsc_pkg::RSC_ST_RUN);

  // bus-class register: cleared by either reset unless suspended
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      cfg_q <= DATA_W'(`RSC_CFG_RST);
    end
    else
    begin
      case (state_d)
        rsc_pkg::RSC_ST_COLD:
        begin
          cfg_q <= DATA_W'(`RSC_CFG_RST);
        end
        rsc_pkg::RSC_ST_BUS:
        begin
          cfg_q <= DATA_W'(`RSC_CFG_RST);
        end
        rsc_pkg::RSC_ST_HOLD:
        begin
          cfg_q <= cfg_q;
        end
        default:
        begin
          if (wr_ok && i_wr_cfg)
          begin
            cfg_q <= i_wr_data;
          end
        end
      endcase
    end
  end

  // wake context survives bus reset so a deep-sleep wake keeps its cause
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      wake_q <= DATA_W'(`RSC_WAKE_RST);
    end
    else
    begin
      case (state_d)
        rsc_pkg::RSC_ST_COLD:
        begin
          wake_q <= DATA_W'(`RSC_WAKE_RST);
        end
        rsc_pkg::RSC_ST_BUS:
        begin
          wake_q <= wake_q;
        end
        rsc_pkg::RSC_ST_HOLD:
        begin
          wake_q <= wake_q;
        end
        default:
        begin
          if (wr_ok && i_wr_wake)
          begin
            wake_q <= i_wr_data;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_out_en   = out_en_q;
  assign o_func_en  = func_en_q;
  assign o_clr_all  = clr_all_q;
  assign o_clr_bus  = clr_bus_q;
  assign o_state    = state_q;
  assign o_cfg      = cfg_q;
  assign o_wake_ctx = wake_q;

endmodule

`default_nettype wire

// File: tb/rsc_host_model.sv
// host side model: bus clock domain driver of the reset and suspend pins
`timescale 1ns/1ps
`default_nettype none
module rsc_host_model (
  // clock and commands
  input  wire logic i_clk,
  input  wire logic i_boot,
  input  wire logic i_bus_rst,
  input  wire logic i_susp,
  input  wire logic i_tied,
  // pins
  output var  logic o_cold_n,
  output var  logic o_bus_n,
  output var  logic o_susp
);
  wire logic any_rst = i_bus_rst || i_boot;
  // pins move on the falling edge, clear of the sampling edge
  always @(negedge i_clk)
  begin
    o_cold_n <= i_tied ? !any_rst : !i_boot;
    o_bus_n  <= i_tied ? !any_rst : !i_bus_rst;
    o_susp   <= i_susp;
  end
endmodule
`default_nettype wire

// File: tb/rsc_top_checker.sv
// assertions on the reset and suspend control ports
`timescale 1ns/1ps
`default_nettype none
module rsc_top_checker #(
  parameter int DATA_W = 8
) (
  input wire logic              i_clk,
  input wire logic              i_rst,
  input wire logic              i_cold_global_reset_n,
  input wire logic              i_host_bus_reset_n,
  input wire logic              i_suspend,
  input wire logic              i_wr_cfg,
  input wire logic [DATA_W-1:0] i_wr_data,
  input wire logic              o_out_en,
  input wire logic              o_func_en,
  input wire logic              o_clr_all,
  input wire logic              o_clr_bus,
  input wire logic [2:0]        o_state,
  input wire logic [DATA_W-1:0] o_cfg,
  input wire logic [DATA_W-1:0] o_wake_ctx
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire logic c_n = i_cold_global_reset_n;
  wire logic b_n = i_host_bus_reset_n;
  wire logic s   = i_suspend;
  // three edges: two sync stages plus the state flop
  property p_cold;
    (!c_n && !s) [*3] |=> o_state == 3'h1 && o_clr_all && o_clr_bus && o_cfg == '0 && o_wake_ctx == '0;
  endproperty
  property p_hold;
    (s && !(c_n && b_n)) [*3] |=> o_state == 3'h3 && !o_clr_all && !o_clr_bus;
  endproperty
  property p_keep;
    o_state == 3'h3 |-> $stable(o_cfg) && $stable(o_wake_ctx);
  endproperty
  property p_bus;
    (c_n && !b_n && !s) [*3] |=> o_state == 3'h2 && o_clr_bus && !o_clr_all && o_cfg == '0;
  endproperty
  property p_wake;
    o_state == 3'h2 |-> $stable(o_wake_ctx);
  endproperty
  property p_run;
    (c_n && b_n) [*3] |=> o_state == 3'h4 && o_out_en && o_func_en && !o_clr_all && !o_clr_bus;
  endproperty
  property p_wr;
    (o_state == 3'h4 && i_wr_cfg ##1 o_state == 3'h4) |-> o_cfg == $past(i_wr_data);
  endproperty
  property p_float;
    o_state != 3'h4 |-> !o_out_en && !o_func_en;
  endproperty
  a_cold: assert property (p_cold) else $error("cold reset outcome wrong");
  a_hold: assert property (p_hold) else $error("suspend hold outcome wrong");
  a_keep: assert property (p_keep) else $error("registers moved in hold");
  a_bus: assert property (p_bus) else $error("bus reset outcome wrong");
  a_wake: assert property (p_wake) else $error("wake context moved in bus reset");
  a_run: assert property (p_run) else $error("no run after resets released");
  a_wr: assert property (p_wr) else $error("cfg write not taken");
  a_float: assert property (p_float) else $error("outputs driven outside run");
  c_hold: cover property (o_state == 3'h3);
  c_bus: cover property (o_state == 3'h2);
  c_wr: cover property (o_state == 3'h4 && i_wr_cfg);
endmodule
bind rsc_top rsc_top_checker #(.DATA_W(DATA_W)) u_chk (.i_clk(i_clk), .i_rst(i_rst),
  .i_cold_global_reset_n(i_cold_global_reset_n), .i_host_bus_reset_n(i_host_bus_reset_n),
  .i_suspend(i_suspend), .i_wr_cfg(i_wr_cfg), .i_wr_data(i_wr_data), .o_out_en(o_out_en),
  .o_func_en(o_func_en), .o_clr_all(o_clr_all), .o_clr_bus(o_clr_bus), .o_state(o_state),
  .o_cfg(o_cfg), .o_wake_ctx(o_wake_ctx));
`default_nettype wire

// File: tb/rsc_top_tb_top.sv
// testbench for the reset and suspend control block
`timescale 1ns/1ps
`default_nettype none
module rsc_top_tb_top;
  typedef struct packed {logic [2:0] st; logic en; logic [7:0] c; logic [7:0] w;} rsc_exp_t;
  logic            i_clk = 1'b0, i_rst = 1'b1, i_wr_cfg = 1'b0, i_wr_wake = 1'b0;
  logic            boot = 1'b1, bus = 1'b0, susp = 1'b0, tied = 1'b0;
  logic [7:0]      i_wr_data = 8'h00, c_e = 8'h00, w_e = 8'h00;
  logic [16:0]     lf = 17'h16841;
  wire logic       cold_n, bus_n, susp_p, o_out_en, o_func_en, o_clr_all, o_clr_bus;
  wire logic [2:0] o_state;
  wire logic [7:0] o_cfg, o_wake_ctx;
  int              miscompares = 0, samples_checked = 0;
  rsc_exp_t        q[$];
  event            ev;
  always #4 i_clk = ~i_clk;
  rsc_host_model u_host (.i_clk(i_clk), .i_boot(boot), .i_bus_rst(bus), .i_susp(susp), .i_tied(tied),
    .o_cold_n(cold_n), .o_bus_n(bus_n), .o_susp(susp_p));
  rsc_top #(.DATA_W(8)) dut (.i_clk(i_clk), .i_rst(i_rst), .i_cold_global_reset_n(cold_n),
    .i_host_bus_reset_n(bus_n), .i_suspend(susp_p), .i_wr_cfg(i_wr_cfg), .i_wr_wake(i_wr_wake),
    .i_wr_data(i_wr_data), .o_out_en(o_out_en), .o_func_en(o_func_en), .o_clr_all(o_clr_all),
    .o_clr_bus(o_clr_bus), .o_state(o_state), .o_cfg(o_cfg), .o_wake_ctx(o_wake_ctx));
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic logic [16:0] lfsr_next(input logic [16:0] v);
    lfsr_next = {v[15:0], v[16] ^ v[13]};
  endfunction
  // outputs while the internal reset is held
  task automatic rst_chk();
    chk("rst_state", {5'h00, o_state}, 8'h00);
    chk("rst_flags", {4'h0, o_out_en, o_func_en, o_clr_all, o_clr_bus}, 8'h03);
    chk("rst_cfg", o_cfg, 8'h00);
    chk("rst_wake", o_wake_ctx, 8'h00);
  endtask
  task automatic step(input logic b, input logic r, input logic p, input logic [2:0] st);
    @(negedge i_clk);
    {boot, bus, susp} <= {b, r, p};
    repeat (5) @(posedge i_clk);
    if (st == 3'h1 || st == 3'h2) c_e = 8'h00;
    if (st == 3'h1) w_e = 8'h00;
    q.push_back('{st, st == 3'h4, c_e, w_e});
    #1 -> ev;
  endtask
  // ok says whether the block is expected to take the write
  task automatic wr(input logic c, input logic w, input logic ok);
    @(negedge i_clk);
    lf = lfsr_next(lf);
    i_wr_data <= lf[7:0];
    {i_wr_cfg, i_wr_wake} <= {c, w};
    @(negedge i_clk);
    {i_wr_cfg, i_wr_wake} <= 2'h0;
    if (ok && c) c_e = lf[7:0];
    if (ok && w) w_e = lf[7:0];
  endtask
  always @(ev)
  begin
    rsc_exp_t e;
    e = q.pop_front();
    chk("state", {5'h00, o_state}, {5'h00, e.st});
    chk("flags", {4'h0, o_out_en, o_func_en, o_clr_all, o_clr_bus},
      {4'h0, e.en, e.en, e.st == 3'h1, e.st == 3'h1 || e.st == 3'h2});
    chk("cfg", o_cfg, e.c);
    chk("wake", o_wake_ctx, e.w);
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #5000;
    miscompares++;
    summarize();
  end
  initial
  begin
    repeat (5) @(posedge i_clk);
    #1 rst_chk();
    @(negedge i_clk);
    i_rst <= 1'b0;
    step(1, 0, 0, 3'h1);
    step(0, 0, 0, 3'h4);
    wr(1, 1, 1);
    step(0, 1, 0, 3'h2);
    // writes during bus reset must be dropped
    wr(1, 1, 0);
    step(0, 1, 0, 3'h2);
    step(0, 0, 0, 3'h4);
    wr(1, 0, 1);
    step(0, 1, 1, 3'h3);
    step(0, 0, 1, 3'h4);
    step(1, 0, 1, 3'h3);
    step(1, 0, 0, 3'h1);
    step(0, 0, 0, 3'h4);
    wr(1, 1, 1);
    // mid-run internal reset: sync stages restart as cold reset, so both registers clear
    @(negedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    #1 rst_chk();
    @(negedge i_clk);
    i_rst <= 1'b0;
    c_e = 8'h00;
    w_e = 8'h00;
    step(0, 0, 0, 3'h4);
    tied <= 1'b1;
    step(0, 1, 0, 3'h1);
    @(negedge i_clk);
    summarize();
  end
endmodule
`default_nettype wire
